// [logic/rcr_bank.v]
// rail control register bank: three 8-bit control registers for two step-down rails and one ldo rail
// assumes a serial management front end on clk delivering byte writes/reads; control pins are asynchronous
//
// Functional notes
// - sleep field 5:4: 00 normal code always, 11 sleep code while sleep pin low
// - each rail's sleep pin is factory chosen: control input three or six
// - step-down bit 1: 0 automatic mode, 1 forced pwm mode
// - bit 0 is software enable; 0 forces rail off regardless of control pins
// - registers decoded at 26h, 27h, 28h; reset values are factory parameters
`timescale 1ns/100ps
`include "rcr_map.vh"

module rcr_bank #(
	parameter [7:0] RST_STEP5   = `RCR_RST_STEP5,
	parameter [7:0] RST_STEP6   = `RCR_RST_STEP6,
	parameter [7:0] RST_LDO2    = `RCR_RST_LDO2,
	parameter [2:0] SLP_PIN_SEL = 3'h0,
	parameter [2:0] CTL_SEL5    = 3'h0,
	parameter [2:0] CTL_SEL6    = 3'h1,
	parameter [2:0] CTL_SEL_LDO = 3'h2
) (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	output reg        reg_hit,
	input  wire [5:0] control_input_pins,
	output reg  [2:0] rail_run,
	output reg  [2:0] rail_use_sleep_code,
	output reg  [1:0] rail_pwm_force
);

////////////////////////////////////////////////////////////////////////////////
// control pin synchronisers; SLP_PIN_SEL bit n picks sleep pin for rail n (0: input three, 1: input six)

reg  [5:0] pin_meta_r;
reg  [5:0] pin_sync_r;

always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
		pin_meta_r <= 6'h00;
	else
		pin_meta_r <= control_input_pins;
end

// only the second stage feeds logic; the first may still be settling
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
		pin_sync_r <= 6'h00;
	else
		pin_sync_r <= pin_meta_r;
end

wire control_in_three_sleep_one = pin_sync_r[2];
wire control_in_six_sleep_two   = pin_sync_r[5];

////////////////////////////////////////////////////////////////////////////////
// register storage

reg  [7:0] step_down_five_control_r;
reg  [7:0] step_down_six_control_r;
reg  [7:0] low_dropout_two_control_r;
reg  [7:0] step_down_five_control_nxt;
reg  [7:0] step_down_six_control_nxt;
reg  [7:0] low_dropout_two_control_nxt;

wire sel5 = (reg_addr == `RCR_OFS_STEP5);
wire sel6 = (reg_addr == `RCR_OFS_STEP6);
wire sel2 = (reg_addr == `RCR_OFS_LDO2);

// reserved bits stay writable as the host must rewrite them; no hardware enforces the value
always @*
begin
	step_down_five_control_nxt  = step_down_five_control_r;
	step_down_six_control_nxt   = step_down_six_control_r;
	low_dropout_two_control_nxt = low_dropout_two_control_r;
	if (reg_wr)
	begin
		if (sel5)
		begin
			step_down_five_control_nxt = reg_wdata & `RCR_WR_MASK;
		end
		if (sel6)
		begin
			step_down_six_control_nxt = reg_wdata & `RCR_WR_MASK;
		end
		if (sel2)
		begin
			low_dropout_two_control_nxt = reg_wdata & `RCR_WR_MASK;
		end
	end
end

// reset image is the variant's factory setting with 7:6 cleared
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		step_down_five_control_r  <= RST_STEP5 & `RCR_WR_MASK;
		step_down_six_control_r   <= RST_STEP6 & `RCR_WR_MASK;
		low_dropout_two_control_r <= RST_LDO2 & `RCR_WR_MASK;
	end
	else
	begin
		step_down_five_control_r  <= step_down_five_control_nxt;
		step_down_six_control_r   <= step_down_six_control_nxt;
		low_dropout_two_control_r <= low_dropout_two_control_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// read path; unmapped offsets return zero with reg_hit low

reg  [7:0] reg_rdata_nxt;
reg        reg_hit_nxt;

// read data holds between reads so a slow front end can pick it up late
always @*
begin
	reg_rdata_nxt = reg_rdata;
	reg_hit_nxt   = 1'b0;
	if (reg_rd)
	begin
		reg_hit_nxt = sel5 | sel6 | sel2;
		case (reg_addr)
			`RCR_OFS_STEP5:
			begin
				reg_rdata_nxt = step_down_five_control_r;
			end
			`RCR_OFS_STEP6:
			begin
				reg_rdata_nxt = step_down_six_control_r;
			end
			`RCR_OFS_LDO2:
			begin
				reg_rdata_nxt = low_dropout_two_control_r;
			end
			default:
			begin
				reg_rdata_nxt = 8'h00;
			end
		endcase
	end
end

always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		reg_rdata <= 8'h00;
		reg_hit   <= 1'b0;
	end
	else
	begin
		reg_rdata <= reg_rdata_nxt;
		reg_hit   <= reg_hit_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// per-rail outputs: run and sleep from one generate loop over the three rails, pwm force for the two step-down rails

wire [23:0] ctl_all = {low_dropout_two_control_r, step_down_six_control_r, step_down_five_control_r};
wire [8:0]  ctl_sel = {CTL_SEL_LDO, CTL_SEL6, CTL_SEL5};
wire [2:0]  run_nxt;
wire [2:0]  slp_nxt;

genvar g;
generate
	for (g = 0; g < 3; g = g + 1)
	begin : g_rail
		wire [7:0] cr      = ctl_all[g*8 +: 8];
		wire       slp_pin = SLP_PIN_SEL[g] ? control_in_six_sleep_two : control_in_three_sleep_one;
		wire [1:0] slp_fld = cr[`RCR_SLP_HI:`RCR_SLP_LO];
		// reserved codes 01/10 treated as disabled so a stray write never enters sleep
		wire       slp_on  = (slp_fld == `RCR_SLP_ON);
		wire       en_bit  = cr[`RCR_EN_BIT];
		wire       ctl_pin = pin_sync_r[ctl_sel[g*3 +: 3]];
		assign slp_nxt[g] = slp_on & ~slp_pin;
		assign run_nxt[g] = en_bit & ctl_pin;
	end
endgenerate

always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		rail_run            <= 3'h0;
		rail_use_sleep_code <= 3'h0;
	end
	else
	begin
		rail_run            <= run_nxt;
		rail_use_sleep_code <= slp_nxt;
	end
end

// the ldo rail has no mode bit, so only the two step-down rails get one
wire [1:0] pwm_nxt = {step_down_six_control_r[`RCR_PWM_BIT],
	step_down_five_control_r[`RCR_PWM_BIT]};

always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
		rail_pwm_force <= 2'h0;
	else
		rail_pwm_force <= pwm_nxt;
end

endmodule // rcr_bank

// [logic/rcr_map.vh]
// register map, field positions and reset defaults of the rail control register bank
// included by the bank module; definitions only
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

`define RCR_ADDR_W           8
`define RCR_OFS_STEP5        8'h26
`define RCR_OFS_STEP6        8'h27
`define RCR_OFS_LDO2         8'h28

`define RCR_SLP_HI           5
`define RCR_SLP_LO           4
`define RCR_PWM_BIT          1
`define RCR_EN_BIT           0
`define RCR_SLP_OFF          2'h0
`define RCR_SLP_ON           2'h3

// writable bits: 5:0 in every register, 7:6 read as zero
`define RCR_WR_MASK          8'h3F

// factory defaults, overridable per variant by module parameters
`define RCR_RST_STEP5        8'h0F
`define RCR_RST_STEP6        8'h0D
`define RCR_RST_LDO2         8'h0C

`endif

// [verif/rcr_bank_bench.sv]
// random register and pin traffic against the rail control bank
// assumes rail6 sleeps on input six, the others on input three; rail n enabled by input n
`timescale 1ns/100ps
module rcr_bank_bench;
	reg        clk = 1'b0, rst_b = 1'b0;
	reg  [5:0] control_input_pins = 6'h00;
	wire       reg_wr, reg_rd, reg_hit;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire [2:0] rail_run, rail_use_sleep_code;
	wire [1:0] rail_pwm_force;
	reg  [7:0] ex [0:2] = '{8'h0F, 8'h0D, 8'h0C};
	reg [31:0] rs = 97;
	integer    err_count = 0, samples_checked = 0, i, k;
	rcr_bank #(.SLP_PIN_SEL(3'h2)) rcr_bank_i (.*);
	rcr_host rcr_host_i (.*);
	function [31:0] xs(input [31:0] x);
		xs = x ^ (x << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	function [7:0] eo(input [5:0] p);
		integer j;
		for (j = 0; j < 3; j++) {eo[j + 3], eo[j]} = {ex[j][5:4] == 2'h3 && !(j == 1 ? p[5] : p[2]), ex[j][0] & p[j]};
		eo[7:6] = {ex[1][1], ex[0][1]};
	endfunction
	task chk(input [8:0] g, input [8:0] e);
		samples_checked = samples_checked + 1;
		err_count = err_count + (g !== e);
		if (g !== e) $display("mismatch %0t got %h exp %h", $time, g, e);
	endtask
	task give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial forever #20 clk = ~clk;
	initial
	begin
		#600000 err_count = err_count + 1;
		give_verdict;
	end
	initial
	begin
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		for (i = 0; i < 300; i++)
		begin
			rs = xs(rs);
			k = i < 3 ? i : rs[2:0] % 5 - 1;
			if (i > 2 && rs[3])
			begin
				rcr_host_i.wr(k + 38, rs[15:8]);
				if (k >= 0 && k < 3) ex[k] = rcr_host_i.fix(k + 38, rs[15:8]) & 8'h3F;
			end
			rcr_host_i.rd(k + 38);
			chk({reg_hit, reg_rdata}, k >= 0 && k < 3 ? {1'b1, ex[k]} : 9'h000);
			control_input_pins = rs[21:16];
			repeat (4) @(negedge clk);
			chk({1'b0, rail_pwm_force, rail_use_sleep_code, rail_run}, {1'b0, eo(control_input_pins)});
		end
		$display("random traffic done");
		give_verdict;
	end
endmodule // rcr_bank_bench

// [verif/rcr_bank_monitor.sv]
// port checker of the rail control bank
// assumes default bank parameters
`timescale 1ns/100ps
module rcr_bank_monitor (
	input wire       clk, rst_b, reg_wr, reg_rd, reg_hit,
	input wire [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire [5:0] control_input_pins,
	input wire [2:0] rail_run, rail_use_sleep_code,
	input wire [1:0] rail_pwm_force
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire m = reg_addr > 8'h25 && reg_addr < 8'h29;
	wire w = reg_wr && reg_addr == 8'h26;
	AST_HIT: assert property (reg_rd |=> reg_hit == $past(m)) else $error("hit");
	AST_TOP: assert property (reg_hit |-> reg_rdata[7:6] == 2'h0) else $error("top");
	AST_PWM: assert property (w |-> ##2 rail_pwm_force[0] == $past(reg_wdata[1], 2)) else $error("pwm");
	AST_EN: assert property (w && !reg_wdata[0] |-> ##2 !rail_run[0]) else $error("en");
	AST_SLP: assert property (w && reg_wdata[5:4] != 2'h3 |-> ##2 !rail_use_sleep_code[0]) else $error("slp");
	// three edges: two synchroniser stages plus the output flop
	AST_PIN: assert property (rail_use_sleep_code[0] |-> !$past(control_input_pins[2], 3)) else $error("pin");
	AST_RUN: assert property (rail_run[0] |-> $past(control_input_pins[0], 3)) else $error("run");
endmodule // rcr_bank_monitor
bind rcr_bank rcr_bank_monitor rcr_bank_monitor_i (.*);

// [verif/rcr_host.sv]
// host end of the management bus
// assumes the bank takes a strobe at the rising edge after it is raised
`timescale 1ns/100ps
module rcr_host (
	input  wire       clk,
	output reg        reg_wr = 1'b0,
	output reg        reg_rd = 1'b0,
	output reg  [7:0] reg_addr = 8'h00,
	output reg  [7:0] reg_wdata = 8'h00
);
	function [7:0] fix(input [7:0] a, input [7:0] d);
		fix = {d[7:6], {2{d[5]}}, a == 8'h28 ? 3'h6 : {2'h3, d[1]}, d[0]};
	endfunction
	// released lines invert so stale values never look valid
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, fix(a, d), 1'b1};
		@(negedge clk) {reg_addr, reg_wdata, reg_wr} = {~reg_addr, ~reg_wdata, 1'b0};
	endtask
	task rd(input [7:0] a);
		@(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
		@(negedge clk) {reg_addr, reg_rd} = {~a, 1'b0};
	endtask
endmodule // rcr_host
